// ===== rtl/pmm3_bank.sv
// Mode-3 configuration registers and reset-cause monitor
`default_nettype none
module pmm3_bank #(
  parameter int unsigned DEBOUNCE_CYCLES = pmm3_pkg::DEBOUNCE_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Register port from the serial target
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  // Device state and events
  input wire logic [1:0] ACTIVE_MODE,
  input wire pmm3_pkg::pmm3_evt_s EVENTS,
  input wire logic BUTTON_PIN,
  input wire logic MODE_PIN_LOW,
  input wire logic MODE_PIN_HIGH,
  input wire logic MODE_BIT_LOW_SW,
  input wire logic MODE_BIT_HIGH_SW,
  // Controls toward the power stage
  output pmm3_pkg::pmm3_rail_s RAILS,
  output logic SHIP_REQ,
  output logic [1:0] MODE_REQ,
  output logic MODE0_REQ,
  output logic [1:0] WATCHDOG_PERIOD
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] part0;
    logic [7:0] part1;
    logic [7:0] part2;
    logic [7:0] part3;
    logic [4:0] flags;
    logic btn_prev;
    logic [7:0] rdata;
    logic rvalid;
    pmm3_pkg::pmm3_rail_s rails;
    logic ship;
    logic [1:0] mode_req;
    logic mode0;
    logic [1:0] wdog;
  } pmm3_state_s;

  pmm3_state_s st_r;
  pmm3_state_s st_nxt;
  logic btn_level;
  logic mode3;
  logic defaults;
  logic [4:0] sets;
  logic [4:0] clears;
  logic [7:0] cause_view;

  // ----------------------------------------------------------------
  // Button filter
  // ----------------------------------------------------------------
  pmm3_debounce #(
    .LOW_CYCLES(DEBOUNCE_CYCLES)
  ) u_deb (
    .clk(CLK),
    .rst(RST),
    .raw(BUTTON_PIN),
    .level(btn_level)
  );

  // ----------------------------------------------------------------
  // Voltage decoders
  // ----------------------------------------------------------------
  // Core buck: linear up to the top code, flat above, one boost code
  function automatic logic [11:0] core_mv(input logic [5:0] code);
    logic [11:0] v;
    v = pmm3_pkg::CORE_TOP_MV;
    if (code == pmm3_pkg::CORE_BOOST_CODE) begin
      v = pmm3_pkg::CORE_BOOST_MV; // RULE_03
    end else if (code <= pmm3_pkg::CORE_TOP_CODE) begin
      v = pmm3_pkg::CORE_BASE_MV + 12'(code) * pmm3_pkg::STEP_MV; // RULE_03
    end
    return v;
  endfunction

  // System rails share one scale; the offset shifts the whole range
  function automatic logic [11:0] sys_mv(input logic [4:0] code, input logic hi);
    logic [4:0] c;
    logic [11:0] v;
    c = (code > pmm3_pkg::SYS_TOP_CODE) ? pmm3_pkg::SYS_TOP_CODE : code;
    v = pmm3_pkg::SYS_BASE_MV + 12'(c) * pmm3_pkg::STEP_MV;
    if (hi) begin
      v = v + pmm3_pkg::OFFSET_MV;
    end
    return v;
  endfunction

  // Always-on regulator saturates at its top code
  function automatic logic [11:0] aon_mv(input logic [3:0] code);
    logic [3:0] c;
    c = (code > pmm3_pkg::AON_TOP_CODE) ? pmm3_pkg::AON_TOP_CODE : code;
    return pmm3_pkg::AON_BASE_MV + 12'(c) * pmm3_pkg::STEP_MV; // RULE_07
  endfunction

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  // Every cause except the watchdog reloads all four parts
  assign mode3 = (ACTIVE_MODE == pmm3_pkg::MODE_THREE);
  assign defaults = EVENTS.thermal_exit | EVENTS.ship_exit
                  | EVENTS.soft_reset | EVENTS.long_press; // RULE_18

  // Cause flags, one bit each
  always_comb begin
    sets = '0;
    sets[pmm3_pkg::FLAG_THERMAL] = EVENTS.thermal_exit; // RULE_15
    sets[pmm3_pkg::FLAG_SHIP] = EVENTS.ship_exit; // RULE_16
    sets[pmm3_pkg::FLAG_SOFT] = EVENTS.soft_reset; // RULE_17
    sets[pmm3_pkg::FLAG_WDOG] = EVENTS.watchdog_reset; // RULE_18
    sets[pmm3_pkg::FLAG_LONG] = EVENTS.long_press; // RULE_19
  end

  // Write-one-to-clear plus ship cycling, which clears every flag but the ship flag
  always_comb begin
    clears = '0;
    if (REG_WR && REG_ADDR == pmm3_pkg::ADDR_CAUSE) begin
      clears = REG_WDATA[4:0];
    end
    if (EVENTS.ship_cycle) begin
      clears = clears | ~(5'h01 << pmm3_pkg::FLAG_SHIP); // RULE_13
    end
  end

  // Live view of the cause register; reserved bits read zero
  assign cause_view = {btn_level, 2'b00, st_r.flags}; // RULE_14

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    st_nxt.mode0 = 1'b0;
    st_nxt.btn_prev = btn_level;
    // Register writes, then a default reload that overrides them
    if (REG_WR) begin
      if (REG_ADDR == pmm3_pkg::ADDR_PART0) begin
        st_nxt.part0 = REG_WDATA;
      end else if (REG_ADDR == pmm3_pkg::ADDR_PART1) begin
        st_nxt.part1 = REG_WDATA;
      end else if (REG_ADDR == pmm3_pkg::ADDR_PART2) begin
        st_nxt.part2 = REG_WDATA;
      end else if (REG_ADDR == pmm3_pkg::ADDR_PART3) begin
        st_nxt.part3 = REG_WDATA;
      end
    end
    if (defaults) begin
      st_nxt.part0 = pmm3_pkg::RST_PART0; // RULE_01
      st_nxt.part1 = pmm3_pkg::RST_PART1; // RULE_04
      st_nxt.part2 = pmm3_pkg::RST_PART2; // RULE_08
      st_nxt.part3 = pmm3_pkg::RST_PART3; // RULE_09
    end
    // Set beats clear so no cause is lost in the clearing cycle
    st_nxt.flags = (st_r.flags & ~clears) | sets; // RULE_15
    // Read data is registered; unmapped addresses answer zero
    if (REG_RD) begin
      st_nxt.rvalid = 1'b1;
      if (REG_ADDR == pmm3_pkg::ADDR_PART0) begin
        st_nxt.rdata = st_r.part0;
      end else if (REG_ADDR == pmm3_pkg::ADDR_PART1) begin
        st_nxt.rdata = st_r.part1;
      end else if (REG_ADDR == pmm3_pkg::ADDR_PART2) begin
        st_nxt.rdata = st_r.part2;
      end else if (REG_ADDR == pmm3_pkg::ADDR_PART3) begin
        st_nxt.rdata = st_r.part3;
      end else if (REG_ADDR == pmm3_pkg::ADDR_CAUSE) begin
        st_nxt.rdata = cause_view; // RULE_12
      end else begin
        st_nxt.rdata = 8'h00;
      end
    end
    // Controls follow the stored fields only while mode 3 is active
    if (mode3) begin
      st_nxt.ship = st_r.part0[pmm3_pkg::BIT_SHIP]; // RULE_01
      if (st_r.part0[pmm3_pkg::BIT_SRC_PINS]) begin
        st_nxt.mode_req = {MODE_PIN_HIGH, MODE_PIN_LOW}; // RULE_02
      end else begin
        st_nxt.mode_req = {MODE_BIT_HIGH_SW, MODE_BIT_LOW_SW}; // RULE_02
      end
      st_nxt.rails.core_mv = core_mv(st_r.part0[5:0]); // RULE_03
      st_nxt.rails.sys_buck_mv = sys_mv(st_r.part1[4:0],
        st_r.part1[pmm3_pkg::BIT_HIGH_RANGE]); // RULE_05 RULE_06
      st_nxt.rails.aon_mv = aon_mv(st_r.part2[7:4]); // RULE_07
      st_nxt.rails.en = st_r.part2[3:0]; // RULE_08
      st_nxt.rails.sys_ldo_mv = sys_mv(st_r.part3[4:0],
        st_r.part3[pmm3_pkg::BIT_HIGH_RANGE]); // RULE_10 RULE_11
      st_nxt.wdog = st_r.part3[7:6]; // RULE_09
      // Filtered falling edge asks for mode 0 unless told to stay
      st_nxt.mode0 = st_r.btn_prev & ~btn_level
                   & ~st_r.part1[pmm3_pkg::BIT_BTN_KEEP]; // RULE_04
    end else begin
      st_nxt.ship = 1'b0; // RULE_20
      st_nxt.mode_req = 2'h0;
      st_nxt.rails = '0;
      st_nxt.wdog = 2'h0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      st_r <= '0;
      st_r.part0 <= pmm3_pkg::RST_PART0;
      st_r.part1 <= pmm3_pkg::RST_PART1;
      st_r.part2 <= pmm3_pkg::RST_PART2;
      st_r.part3 <= pmm3_pkg::RST_PART3;
      st_r.flags <= pmm3_pkg::RST_FLAGS;
      st_r.btn_prev <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign REG_RDATA = st_r.rdata;
  assign REG_RVALID = st_r.rvalid;
  assign RAILS = st_r.rails;
  assign SHIP_REQ = st_r.ship;
  assign MODE_REQ = st_r.mode_req;
  assign MODE0_REQ = st_r.mode0;
  assign WATCHDOG_PERIOD = st_r.wdog;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  // Mode 3 must hold while the written field travels into the control flop
  sequence hold_mode3;
    mode3 [*2];
  endsequence
  sequence ship_written;
    REG_WR && REG_ADDR == pmm3_pkg::ADDR_PART0 && REG_WDATA[7] && !defaults;
  endsequence

  ship_request_a: assert property (ship_written ##1 hold_mode3 |=> SHIP_REQ) // RULE_01
    else $error("ship request not raised after write");
  mode_source_a: assert property (
    mode3 && st_r.part0[6] |=> MODE_REQ == $past({MODE_PIN_HIGH, MODE_PIN_LOW})) // RULE_02
    else $error("mode pins not selected");
  core_boost_a: assert property (
    mode3 && st_r.part0[5:0] == 6'h3F |=> RAILS.core_mv == 12'd1800) // RULE_03
    else $error("core boost code wrong");
  button_mode0_a: assert property (
    mode3 && $fell(btn_level) && !st_r.part1[6] |=> MODE0_REQ) // RULE_04
    else $error("button edge did not request mode 0");
  button_keep_a: assert property (st_r.part1[6] |=> !MODE0_REQ) // RULE_04
    else $error("mode 0 requested while keeping mode");
  buck_range_a: assert property (
    mode3 && st_r.part1[5] |=> RAILS.sys_buck_mv >= 12'd2700 && RAILS.sys_buck_mv <= 12'd3300) // RULE_05
    else $error("system buck offset range wrong");
  ldo_sat_a: assert property ( // RULE_11
    mode3 && st_r.part3[4:0] > 5'h18
    |=> RAILS.sys_ldo_mv == ($past(st_r.part3[5]) ? 12'hCE4 : 12'h834))
    else $error("system regulator not saturated");
  aon_sat_a: assert property (
    mode3 && st_r.part2[7:4] > 4'h8 |=> RAILS.aon_mv == 12'd1900) // RULE_07
    else $error("always-on regulator not saturated");
  idle_rails_a: assert property (!mode3 [*2] |-> RAILS.en == 4'h0 && WATCHDOG_PERIOD == 2'h0) // RULE_20
    else $error("mode-3 controls active outside mode 3");
  cause_set_a: assert property (|sets |=> (st_r.flags & $past(sets)) == $past(sets)) // RULE_15
    else $error("cause flag lost");
  ship_keep_a: assert property (
    EVENTS.ship_cycle && st_r.flags[3] && !(REG_WR && REG_ADDR == 8'h71 && REG_WDATA[3])
    |=> st_r.flags[3]) // RULE_13
    else $error("ship flag lost on ship cycle");
  wdog_keep_a: assert property (
    EVENTS.watchdog_reset && !defaults && !REG_WR |=> $stable(st_r.part3)) // RULE_18
    else $error("watchdog reset changed settings");
  cause_read_a: assert property (
    REG_RD && REG_ADDR == 8'h71 |=> REG_RVALID && REG_RDATA[7] == $past(btn_level)
    && REG_RDATA[6:5] == 2'b00) // RULE_14
    else $error("cause register read wrong");

  // Register port answers: one valid pulse per read, data held between reads
  read_answer_a: assert property (REG_RD |=> REG_RVALID) // RULE_12
    else $error("read not answered");
  read_single_a: assert property (!REG_RD |=> !REG_RVALID) // RULE_12
    else $error("valid without a read");
  rdata_hold_a: assert property (!REG_RD |=> $stable(REG_RDATA)) // RULE_12
    else $error("read data moved without a read");

  // Controls track the stored fields one cycle later in mode 3
  enable_follow_a: assert property ( // RULE_08
    mode3 |=> RAILS.en == $past(st_r.part2[3:0]))
    else $error("rail enables do not follow the register");
  wdog_follow_a: assert property ( // RULE_09
    mode3 |=> WATCHDOG_PERIOD == $past(st_r.part3[7:6]))
    else $error("watchdog period does not follow the register");
  core_flat_a: assert property ( // RULE_03
    mode3 && st_r.part0[5:0] > 6'h28 && st_r.part0[5:0] != 6'h3F
    |=> RAILS.core_mv == 12'h5DC)
    else $error("core buck not flat above the top code");
  aon_range_a: assert property ( // RULE_07
    mode3 |=> RAILS.aon_mv >= 12'h6A4 && RAILS.aon_mv <= 12'h76C)
    else $error("always-on regulator out of range");
  ship_idle_a: assert property (!mode3 |=> !SHIP_REQ && MODE_REQ == 2'h0) // RULE_20
    else $error("ship or mode request outside mode 3");
  mode0_pulse_a: assert property (MODE0_REQ |=> !MODE0_REQ) // RULE_04
    else $error("mode 0 request longer than one cycle");
  button_rise_a: assert property (BUTTON_PIN |=> btn_level) // RULE_14
    else $error("button high level delayed");

  // Cause flags: a clear only drops bits that no event sets in that cycle
  sequence cause_write;
    REG_WR && REG_ADDR == pmm3_pkg::ADDR_CAUSE && sets == 5'h00;
  endsequence
  sequence quiet_ship_cycle;
    EVENTS.ship_cycle && sets == 5'h00;
  endsequence
  flag_clear_a: assert property ( // RULE_15
    cause_write |=> (st_r.flags & $past(REG_WDATA[4:0])) == 5'h00)
    else $error("cause flag not cleared by write");
  cycle_clear_a: assert property ( // RULE_13
    quiet_ship_cycle |=> (st_r.flags & 5'h17) == 5'h00)
    else $error("cause flags kept over ship cycling");

  // Every reloading event leaves the four parts at their reset values
  defaults_reload_a: assert property ( // RULE_16 RULE_17 RULE_19
    defaults |=> st_r.part0 == pmm3_pkg::RST_PART0
    && st_r.part1 == pmm3_pkg::RST_PART1 && st_r.part2 == pmm3_pkg::RST_PART2
    && st_r.part3 == pmm3_pkg::RST_PART3)
    else $error("defaults not reloaded");
endmodule
`default_nettype wire

// ===== rtl/pmm3_pkg.sv
// Constants and types for the mode-3 configuration and reset-cause bank
// Operation
// RULE_01: Part-0 bit 7 requests ship mode in mode 3; resets to 0.
// RULE_02: Part-0 bit 6 picks mode source: 0 software bits, 1 mode pins.
// RULE_03: Core buck code: 0.5 V plus 25 mV steps to 1.5 V; 63 is 1.8 V.
// RULE_04: Part-1 bit 6 at 0 makes button falling edge return to mode 0.
// RULE_05: Part-1 bit 5 adds 1.2 V to the system buck output.
// RULE_06: System buck code: 1.5 V plus 25 mV steps, saturates at 2.1 V.
// RULE_07: Always-on regulator code in bits 7:4: 1.7 V to 1.9 V, resets 0100.
// RULE_08: Part-2 bits 3..0 enable core buck, system buck, aon, system LDO.
// RULE_09: Watchdog field bits 7:6: off, 16 s, 32 s, 64 s; resets off.
// RULE_10: Part-3 bit 5 adds 1.2 V to the system regulator output.
// RULE_11: System regulator code: 1.5 V plus 25 mV steps, saturates at 2.1 V.
// RULE_12: Reset-cause register at 0x71 tells software why supplies cycled.
// RULE_13: Ship-exit flag survives ship cycling; other cause flags clear.
// RULE_14: Bit 7 shows button level; low debounced 5 ms, high instant.
// RULE_15: Bit 4 set on thermal shutdown exit; write 1 clears.
// RULE_16: Bit 3 set on ship mode exit; write 1 clears.
// RULE_17: Bit 2 set after software reset command; write 1 clears.
// RULE_18: Bit 1 set after watchdog reset, which keeps all settings.
// RULE_19: Bit 0 set after long button press reset; write 1 clears.
// RULE_20: Mode-3 fields drive rails and watchdog only while mode 3 active.
`default_nettype none
package pmm3_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PART0 = 8'h2E;
  localparam logic [7:0] ADDR_PART1 = 8'h2F;
  localparam logic [7:0] ADDR_PART2 = 8'h30;
  localparam logic [7:0] ADDR_PART3 = 8'h31;
  localparam logic [7:0] ADDR_CAUSE = 8'h71;
  localparam logic [7:0] RST_PART0 = 8'h1C;
  localparam logic [7:0] RST_PART1 = 8'h4C;
  localparam logic [7:0] RST_PART2 = 8'h4F;
  localparam logic [7:0] RST_PART3 = 8'h0C;
  localparam logic [4:0] RST_FLAGS = 5'h00;
  // Field positions
  localparam int BIT_SHIP = 7;
  localparam int BIT_SRC_PINS = 6;
  localparam int BIT_BTN_KEEP = 6;
  localparam int BIT_HIGH_RANGE = 5;
  localparam int BIT_BTN_LEVEL = 7;
  localparam int FLAG_THERMAL = 4;
  localparam int FLAG_SHIP = 3;
  localparam int FLAG_SOFT = 2;
  localparam int FLAG_WDOG = 1;
  localparam int FLAG_LONG = 0;
  localparam logic [1:0] MODE_THREE = 2'h3;
  // ----------------------------------------------------------------
  // Output voltage scales in millivolts
  // ----------------------------------------------------------------
  localparam logic [11:0] STEP_MV = 12'h019;
  localparam logic [11:0] CORE_BASE_MV = 12'h1F4;
  localparam logic [11:0] CORE_TOP_MV = 12'h5DC;
  localparam logic [11:0] CORE_BOOST_MV = 12'h708;
  localparam logic [5:0] CORE_TOP_CODE = 6'h28;
  localparam logic [5:0] CORE_BOOST_CODE = 6'h3F;
  localparam logic [11:0] SYS_BASE_MV = 12'h5DC;
  localparam logic [4:0] SYS_TOP_CODE = 5'h18;
  localparam logic [11:0] OFFSET_MV = 12'h4B0;
  localparam logic [11:0] AON_BASE_MV = 12'h6A4;
  localparam logic [3:0] AON_TOP_CODE = 4'h8;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int DEBOUNCE_MS = 5;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int DEB_W = 18;
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic thermal_exit;
    logic ship_exit;
    logic soft_reset;
    logic watchdog_reset;
    logic long_press;
    logic ship_cycle;
  } pmm3_evt_s;
  typedef struct packed {
    logic [11:0] core_mv;
    logic [11:0] sys_buck_mv;
    logic [11:0] aon_mv;
    logic [11:0] sys_ldo_mv;
    logic [3:0] en;
  } pmm3_rail_s;
endpackage
`default_nettype wire

// ===== rtl/pmm3_debounce.sv
// Button level filter: low must persist, high passes at once
`default_nettype none
module pmm3_debounce #(
  parameter int unsigned LOW_CYCLES = 200000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Raw and filtered level
  input wire logic raw,
  output logic level
);
  typedef struct packed {
    logic [pmm3_pkg::DEB_W-1:0] cnt;
    logic lvl;
  } pmm3_deb_s;
  typedef logic [pmm3_pkg::DEB_W-1:0] pmm3_cnt_t;
  localparam pmm3_cnt_t LIMIT = pmm3_cnt_t'(LOW_CYCLES - 1);
  pmm3_deb_s st_r;
  pmm3_deb_s st_nxt;
  // High releases the filter instantly, low is counted out
  always_comb begin
    st_nxt = st_r;
    if (raw) begin
      st_nxt.cnt = '0;
      st_nxt.lvl = 1'b1; // RULE_14
    end else if (st_r.lvl) begin
      if (st_r.cnt >= LIMIT) begin
        st_nxt.lvl = 1'b0; // RULE_14
      end else begin
        st_nxt.cnt = st_r.cnt + pmm3_cnt_t'(1);
      end
    end
  end
  // Level resets high so a held button is not seen before its delay
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '{cnt: '0, lvl: 1'b1};
    end else begin
      st_r <= st_nxt;
    end
  end
  assign level = st_r.lvl;
endmodule
`default_nettype wire

// ===== tb/pmm3_host.sv
// Host model that reaches the bank one byte at a time
`default_nettype none
module pmm3_host (
  // Clock
  input wire logic clk,
  // Answer from the bank
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  // Request toward the bank
  output logic wr,
  output logic rd,
  output logic [7:0] addr,
  output logic [7:0] wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle port at time zero
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  // One-cycle write strobe; clearing a cause flag is a write of 1 to it
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    addr = ~a; // Released lines never keep the old value
    wdata = ~d;
  endtask
  // One-cycle read strobe; the answer stands only in the cycle after the
  // strobe edge, so it is taken mid-cycle before the valid pulse ends
  task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    ok = rvalid;
    d = rdata;
    rd = 1'b0;
    addr = ~a;
  endtask
endmodule
`default_nettype wire

// ===== tb/pmm3_bank_bench.sv
// Self-checking bench for the mode-3 configuration and reset-cause bank
`default_nettype none
module pmm3_bank_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic clk, rst, wr, rd, rvalid, button, pin_lo, pin_hi, sw_lo, sw_hi;
  logic ship_req, mode0_req;
  logic [7:0] addr, wdata, rdata;
  logic [1:0] active_mode, mode_req, wd_period;
  pmm3_pkg::pmm3_evt_s events;
  pmm3_pkg::pmm3_rail_s rails;
  int n_errors = 0;
  int num_checks = 0;
  int n_mode0 = 0;
  logic [5:0] cc [5] = '{6'h00, 6'h28, 6'h29, 6'h3E, 6'h3F};
  logic [4:0] lc [4] = '{5'h00, 5'h18, 5'h19, 5'h1F};
  logic [7:0] sv [3] = '{8'h1F, 8'h00, 8'h38};
  logic [7:0] v;
  pmm3_bank #(.DEBOUNCE_CYCLES(8)) dut_u (.CLK(clk), .RST(rst), .REG_WR(wr), .REG_RD(rd),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .ACTIVE_MODE(active_mode), .EVENTS(events), .BUTTON_PIN(button),
    .MODE_PIN_LOW(pin_lo), .MODE_PIN_HIGH(pin_hi), .MODE_BIT_LOW_SW(sw_lo),
    .MODE_BIT_HIGH_SW(sw_hi), .RAILS(rails), .SHIP_REQ(ship_req), .MODE_REQ(mode_req),
    .MODE0_REQ(mode0_req), .WATCHDOG_PERIOD(wd_period));
  pmm3_host host_u (.clk(clk), .rdata(rdata), .rvalid(rvalid), .wr(wr), .rd(rd),
    .addr(addr), .wdata(wdata));
  // 40 MHz clock
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  // Return-to-mode-0 pulses are counted mid-cycle, away from the launching edge
  always @(negedge clk) begin
    if (mode0_req === 1'b1) n_mode0++;
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host_u.read(a, d, ok);
    chk({11'h000, ok}, 12'h001, "read valid");
    chk({4'h0, d}, {4'h0, exp}, "read data");
  endtask
  // Register, then control output: three edges cover both stages
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input int b);
    @(negedge clk);
    events = pmm3_pkg::pmm3_evt_s'(6'h01 << b);
    @(negedge clk);
    events = '0;
  endtask
  function automatic logic [11:0] core_exp(input logic [5:0] c);
    if (c == 6'h3F) return pmm3_pkg::CORE_BOOST_MV;
    if (c > 6'h28) return pmm3_pkg::CORE_TOP_MV;
    return pmm3_pkg::CORE_BASE_MV + 12'(c) * pmm3_pkg::STEP_MV;
  endfunction
  // Shared by system buck and system regulator: saturate, then offset
  function automatic logic [11:0] sys_exp(input logic [4:0] c, input logic o);
    logic [11:0] s;
    s = (c > 5'h18) ? 12'h018 : 12'(c);
    return pmm3_pkg::SYS_BASE_MV + s * pmm3_pkg::STEP_MV + (o ? pmm3_pkg::OFFSET_MV : 12'h000);
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    #200us;
    n_errors++;
    summarize();
  end
  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    active_mode = 2'h3;
    events = '0;
    button = 1'b1;
    pin_lo = 1'b0;
    pin_hi = 1'b1;
    sw_lo = 1'b1;
    sw_hi = 1'b0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rdchk(8'h2E, 8'h1C);
    rdchk(8'h2F, 8'h4C);
    rdchk(8'h30, 8'h4F);
    rdchk(8'h31, 8'h0C);
    rdchk(8'h71, 8'h80);
    rdchk(8'h50, 8'h00);
    chk(rails.core_mv, 12'h4B0, "core default");
    chk(rails.sys_buck_mv, 12'h708, "buck default");
    chk(rails.aon_mv, 12'h708, "aon default");
    chk(rails.sys_ldo_mv, 12'h708, "ldo default");
    chk({8'h00, rails.en}, 12'h00F, "enables");
    chk({10'h000, wd_period}, 12'h000, "watchdog off");
    $display("test defaults done");
    foreach (cc[i]) begin
      host_u.write(8'h2E, {2'b00, cc[i]});
      settle();
      chk(rails.core_mv, core_exp(cc[i]), "core code");
    end
    foreach (sv[i]) begin
      host_u.write(8'h2F, sv[i]);
      settle();
      chk(rails.sys_buck_mv, sys_exp(sv[i][4:0], sv[i][5]), "buck code");
    end
    host_u.write(8'h30, 8'h85);
    settle();
    chk({rails.aon_mv[7:0], rails.en}, {8'h6C, 4'h5}, "aon top");
    host_u.write(8'h30, 8'hFA);
    settle();
    chk({rails.aon_mv[7:0], rails.en}, {8'h6C, 4'hA}, "aon sat");
    for (int w = 0; w < 4; w++) begin
      v = {w[1:0], w[0], lc[w]};
      host_u.write(8'h31, v);
      settle();
      chk({10'h000, wd_period}, 12'(w), "watchdog");
      chk(rails.sys_ldo_mv, sys_exp(lc[w], w[0]), "ldo code");
    end
    $display("test rails done");
    host_u.write(8'h2E, 8'h9C);
    settle();
    chk({9'h000, ship_req, mode_req}, 12'h005, "ship soft src");
    host_u.write(8'h2E, 8'h5C);
    settle();
    chk({9'h000, ship_req, mode_req}, 12'h002, "pin src");
    $display("test mode source done");
    @(negedge clk);
    button = 1'b0;
    repeat (4) @(negedge clk);
    button = 1'b1;
    settle();
    chk(12'(n_mode0), 12'h000, "short press");
    @(negedge clk);
    button = 1'b0;
    repeat (12) @(negedge clk);
    rdchk(8'h71, 8'h00);
    chk(12'(n_mode0), 12'h001, "press to mode 0");
    button = 1'b1;
    host_u.write(8'h71, 8'h00);
    rdchk(8'h71, 8'h80);
    // With the keep bit set a long press must not leave mode 3
    host_u.write(8'h2F, 8'h4C);
    button = 1'b0;
    repeat (12) @(negedge clk);
    button = 1'b1;
    settle();
    chk(12'(n_mode0), 12'h001, "keep mode");
    $display("test button done");
    @(negedge clk);
    active_mode = 2'h2;
    settle();
    chk(rails.core_mv | rails.sys_buck_mv, 12'h000, "bucks gated");
    chk(rails.aon_mv | rails.sys_ldo_mv, 12'h000, "regulators gated");
    chk({9'h000, ship_req, mode_req}, 12'h000, "requests gated");
    chk({8'h00, rails.en}, 12'h000, "enables gated");
    chk({10'h000, wd_period}, 12'h000, "watchdog gated");
    host_u.write(8'h30, 8'h3C);
    rdchk(8'h30, 8'h3C);
    active_mode = 2'h3;
    $display("test gating done");
    for (int k = 0; k < 5; k++) begin
      host_u.write(8'h2E, 8'h55);
      pulse(5 - k);
      rdchk(8'h71, 8'h80 | (8'h10 >> k));
      rdchk(8'h2E, (k == 3) ? 8'h55 : 8'h1C);
      host_u.write(8'h71, 8'h10 >> k);
      rdchk(8'h71, 8'h80);
    end
    for (int k = 1; k < 6; k++) pulse(k);
    rdchk(8'h71, 8'h9F);
    pulse(0);
    rdchk(8'h71, 8'h88);
    host_u.write(8'h71, 8'hFF);
    rdchk(8'h71, 8'h80);
    // Clear and event in one cycle: the event must win
    fork
      host_u.write(8'h71, 8'h01);
      pulse(1);
    join
    rdchk(8'h71, 8'h81);
    $display("test reset cause done");
    // Reset in mid-run restores the bank and drops every cause flag
    host_u.write(8'h31, 8'h40);
    settle();
    chk({10'h000, wd_period}, 12'h001, "watchdog 16 s");
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rdchk(8'h31, 8'h0C);
    rdchk(8'h71, 8'h80);
    chk({10'h000, wd_period}, 12'h000, "watchdog after reset");
    $display("test mid-run reset done");
    summarize();
  end
endmodule
`default_nettype wire
